//--- rtl/ccs_regs.svh
// Register map, field positions, codes and timing constants of the clock control block
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
`define CCS_ADDR_CLKSRC 8'ha9
`define CCS_ADDR_MULT 8'hb9
`define CCS_RESET_VAL 8'h00
`define CCS_RDATA_IDLE 8'h00
`define CCS_MC_EN_BIT 7
`define CCS_MC_INIT_BIT 6
`define CCS_MC_RDY_BIT 5
`define CCS_MC_SEL_MSB 1
`define CCS_MC_SEL_LSB 0
`define CCS_MC_WMASK 8'hc3
`define CCS_CS_USB_MSB 6
`define CCS_CS_USB_LSB 4
`define CCS_CS_SYS_MSB 2
`define CCS_CS_SYS_LSB 0
`define CCS_CS_WMASK 8'h77
`define CCS_MSEL_INT 2'b00
`define CCS_MSEL_EXT 2'b01
`define CCS_MSEL_EXT2 2'b10
`define CCS_USB_MULT 3'b000
`define CCS_USB_INT2 3'b001
`define CCS_USB_EXT 3'b010
`define CCS_USB_EXT2 3'b011
`define CCS_USB_EXT3 3'b100
`define CCS_USB_EXT4 3'b101
`define CCS_SYS_INT 3'b000
`define CCS_SYS_EXT 3'b001
`define CCS_SYS_MULT2 3'b010
`define CCS_SYS_MULT 3'b011
`define CCS_SYS_LF 3'b100
`define CCS_MULT_FACTOR 4
`define CCS_CLK_PERIOD_NS 5
`define CCS_MULT_LOCK_NS 2000
`define CCS_SWITCH_NS 20
`endif

//--- rtl/ccs_pkg.sv
// Types shared by the clock control block
package ccs_pkg;
  // Frequency in kHz
  typedef logic [23:0] ccs_khz_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccs_bus_req_t;
  // Oscillator indications from outside the clock domain
  typedef struct packed {
    logic ext_settled;
    logic xtal_mode;
    logic lf_ready;
  } ccs_src_t;
  // Status outputs
  typedef struct packed {
    logic mult_on;
    logic mult_locked;
    logic crystal_valid;
    logic ext_periph_avail;
  } ccs_status_t;
  // Frequencies of the selected clocks
  typedef struct packed {
    ccs_khz_t sys_khz;
    ccs_khz_t usb_khz;
    ccs_khz_t mult_khz;
  } ccs_freq_t;
  // Glitch-free switch sequence
  typedef enum logic [1:0] {ccs_sw_idle, ccs_sw_gate, ccs_sw_settle} ccs_sw_state_t;
endpackage : ccs_pkg

//--- rtl/ccs_top.sv
// Clock multiplier control and system/USB clock source selection
//
// The address-and-strobe port was left to the implementer.
`include "ccs_regs.svh"

// Gated changeover of one clock multiplexer
module ccs_glitch_switch #(
  parameter int unsigned GATE_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] want,
  input wire logic want_ok,
  output logic [2:0] applied,
  output logic hold
);
  import ccs_pkg::*;

  ccs_sw_state_t state; // Sequence state
  logic [15:0] cnt; // Gate time counter
  logic [2:0] pending; // Code being switched to

  // Elaboration check on the gate time
  if (GATE_CYC < 1 || GATE_CYC > 65535) begin : g_bad_gate
    $error("ccs_glitch_switch: GATE_CYC out of range");
  end

  // Old clock is gated off, then the new one is taken, then it runs before release
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ccs_sw_idle;
      cnt <= 16'h0000;
      pending <= 3'h0;
      applied <= 3'h0;
    end else begin
      case (state)
        ccs_sw_idle: begin
          if (want_ok && want != applied) begin
            pending <= want;
            cnt <= 16'h0000;
            state <= ccs_sw_gate;
          end
        end
        ccs_sw_gate: begin
          if (cnt == 16'(GATE_CYC - 1)) begin
            applied <= pending;
            cnt <= 16'h0000;
            state <= ccs_sw_settle;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        // New source runs gated before release
        ccs_sw_settle: begin
          if (cnt == 16'(GATE_CYC - 1)) begin
            state <= ccs_sw_idle;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        default: begin
          state <= ccs_sw_idle;
        end
      endcase
    end
  end

  // Output clock held while the changeover runs
  assign hold = (state != ccs_sw_idle);
endmodule : ccs_glitch_switch

// Top of the clock control block
module ccs_top #(
  parameter int unsigned INT_OSC_KHZ = 12000, // Internal oscillator rate
  parameter int unsigned EXT_OSC_KHZ = 12000, // External oscillator rate
  parameter int unsigned LF_OSC_KHZ = 80 // Low-frequency oscillator rate
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ccs_pkg::ccs_bus_req_t bus,
  output logic [7:0] rdata,
  input wire ccs_pkg::ccs_src_t src_pins,
  input wire logic int_osc_on,
  input wire logic variant_48_strap,
  output logic [1:0] mult_input_sel,
  output logic [2:0] sys_sel,
  output logic [2:0] usb_sel,
  output logic sys_clk_hold,
  output logic usb_clk_hold,
  output ccs_pkg::ccs_status_t status,
  output ccs_pkg::ccs_freq_t freq
);
  import ccs_pkg::*;

  localparam int unsigned LOCK_CYC =
    (`CCS_MULT_LOCK_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS;
  localparam int unsigned GATE_CYC =
    (`CCS_SWITCH_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS;

  // Elaboration check on frequencies
  if (INT_OSC_KHZ == 0 || EXT_OSC_KHZ == 0 || LF_OSC_KHZ == 0 ||
      EXT_OSC_KHZ * `CCS_MULT_FACTOR > 24'hffffff) begin : g_bad_freq
    $error("ccs_top: oscillator frequency out of range");
  end

  ccs_src_t src_meta; // First synchroniser stage
  ccs_src_t src_sync; // Second synchroniser stage
  logic variant_48; // Captured strap
  logic strap_taken; // Strap captured since reset
  logic mult_en; // Multiplier enable bit
  logic mult_init; // Initialise bit as written
  logic [1:0] mult_sel; // Multiplier input field
  logic [2:0] usb_field; // USB clock field as written
  logic [2:0] sys_field; // System clock field as written
  logic lock_run; // Lock sequence running
  logic mult_locked; // Multiplier locked
  logic [15:0] lock_cnt; // Lock time counter
  logic wr_mult; // Write to multiplier control
  logic wr_clksrc; // Write to clock select
  logic ext_ok; // External oscillator settled
  logic mult_src_ok; // Multiplier input available
  logic sys_ok; // Requested system source usable
  logic usb_ok; // Requested USB source usable
  ccs_khz_t next_mult_khz; // Multiplier output rate
  ccs_khz_t next_sys_khz; // System clock rate
  ccs_khz_t next_usb_khz; // USB clock rate

  // Is a system clock code valid and its source ready
  function automatic logic sys_code_ok(input logic [2:0] code, input logic int_on,
                                       input logic ext_r, input logic lock,
                                       input logic lf_r, input logic v48);
    case (code)
      `CCS_SYS_INT: sys_code_ok = int_on;
      `CCS_SYS_EXT: sys_code_ok = ext_r;
      `CCS_SYS_MULT2: sys_code_ok = lock;
      `CCS_SYS_MULT: sys_code_ok = lock & v48;
      `CCS_SYS_LF: sys_code_ok = lf_r;
      default: sys_code_ok = 1'b0;
    endcase
  endfunction : sys_code_ok

  // Is a USB clock code valid and its source ready
  function automatic logic usb_code_ok(input logic [2:0] code, input logic int_on,
                                       input logic ext_r, input logic lock);
    case (code)
      `CCS_USB_MULT: usb_code_ok = lock;
      `CCS_USB_INT2: usb_code_ok = int_on;
      `CCS_USB_EXT, `CCS_USB_EXT2, `CCS_USB_EXT3, `CCS_USB_EXT4: usb_code_ok = ext_r;
      default: usb_code_ok = 1'b0;
    endcase
  endfunction : usb_code_ok

  // Rate of the multiplier input for a given input choice
  function automatic ccs_khz_t mult_in_khz(input logic [1:0] code);
    case (code)
      `CCS_MSEL_INT: mult_in_khz = 24'(INT_OSC_KHZ);
      `CCS_MSEL_EXT: mult_in_khz = 24'(EXT_OSC_KHZ);
      `CCS_MSEL_EXT2: mult_in_khz = 24'(EXT_OSC_KHZ / 2);
      default: mult_in_khz = 24'h000000;
    endcase
  endfunction : mult_in_khz

  // Two-flop synchroniser for the oscillator indications
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= src_pins;
      src_sync <= src_meta;
    end
  end

  // Variant strap caught at the first edge after reset release
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_taken <= 1'b0;
      variant_48 <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      variant_48 <= variant_48_strap;
    end
  end

  // Address decode of writes
  assign wr_mult = bus.wr && bus.addr == `CCS_ADDR_MULT;
  assign wr_clksrc = bus.wr && bus.addr == `CCS_ADDR_CLKSRC;

  // Multiplier control register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mult_en <= 1'b0;
      mult_init <= 1'b0;
      mult_sel <= 2'b00;
    end else if (wr_mult) begin
      mult_en <= bus.wdata[`CCS_MC_EN_BIT];
      mult_init <= bus.wdata[`CCS_MC_INIT_BIT];
      mult_sel <= bus.wdata[`CCS_MC_SEL_MSB:`CCS_MC_SEL_LSB];
    end
  end

  // Clock select register; unused bits are never stored
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      usb_field <= `CCS_USB_MULT;
      sys_field <= `CCS_SYS_INT;
    end else if (wr_clksrc) begin
      usb_field <= bus.wdata[`CCS_CS_USB_MSB:`CCS_CS_USB_LSB];
      sys_field <= bus.wdata[`CCS_CS_SYS_MSB:`CCS_CS_SYS_LSB];
    end
  end

  // Source readiness
  assign ext_ok = src_sync.ext_settled;
  assign mult_src_ok = (mult_sel == `CCS_MSEL_INT) ? int_osc_on :
                       (mult_sel == `CCS_MSEL_EXT || mult_sel == `CCS_MSEL_EXT2) ? ext_ok :
                       1'b0;

  // Lock sequence: started by an init write while already enabled
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lock_run <= 1'b0;
      lock_cnt <= 16'h0000;
      mult_locked <= 1'b0;
    end else if (!mult_en || !mult_src_ok ||
                 (wr_mult && !bus.wdata[`CCS_MC_EN_BIT])) begin
      // Off or input lost: lock is dropped
      lock_run <= 1'b0;
      lock_cnt <= 16'h0000;
      mult_locked <= 1'b0;
    end else if (wr_mult && bus.wdata[`CCS_MC_INIT_BIT]) begin
      lock_run <= 1'b1;
      lock_cnt <= 16'h0000;
      mult_locked <= 1'b0;
    end else if (lock_run) begin
      if (lock_cnt == 16'(LOCK_CYC - 1)) begin
        lock_run <= 1'b0;
        mult_locked <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 16'h0001;
      end
    end
  end

  assign sys_ok = sys_code_ok(sys_field, int_osc_on, ext_ok, mult_locked,
                              src_sync.lf_ready, variant_48);
  assign usb_ok = usb_code_ok(usb_field, int_osc_on, ext_ok, mult_locked);

  // System clock changeover
  ccs_glitch_switch #(.GATE_CYC(GATE_CYC)) u_sys_switch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .want(sys_field),
    .want_ok(sys_ok),
    .applied(sys_sel),
    .hold(sys_clk_hold)
  );

  // USB clock changeover
  ccs_glitch_switch #(.GATE_CYC(GATE_CYC)) u_usb_switch (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .want(usb_field),
    .want_ok(usb_ok),
    .applied(usb_sel),
    .hold(usb_clk_hold)
  );

  // Rates of the selected clocks
  always_comb begin
    next_mult_khz = mult_locked ? 24'(mult_in_khz(mult_sel) * `CCS_MULT_FACTOR) : 24'h000000;
    case (sys_sel)
      `CCS_SYS_INT: next_sys_khz = 24'(INT_OSC_KHZ);
      `CCS_SYS_EXT: next_sys_khz = 24'(EXT_OSC_KHZ);
      `CCS_SYS_MULT2: next_sys_khz = next_mult_khz >> 1;
      `CCS_SYS_MULT: next_sys_khz = next_mult_khz;
      `CCS_SYS_LF: next_sys_khz = 24'(LF_OSC_KHZ);
      default: next_sys_khz = 24'h000000;
    endcase
    case (usb_sel)
      `CCS_USB_MULT: next_usb_khz = next_mult_khz;
      `CCS_USB_INT2: next_usb_khz = 24'(INT_OSC_KHZ / 2);
      `CCS_USB_EXT: next_usb_khz = 24'(EXT_OSC_KHZ);
      `CCS_USB_EXT2: next_usb_khz = 24'(EXT_OSC_KHZ / 2);
      `CCS_USB_EXT3: next_usb_khz = 24'(EXT_OSC_KHZ / 3);
      `CCS_USB_EXT4: next_usb_khz = 24'(EXT_OSC_KHZ / 4);
      default: next_usb_khz = 24'h000000;
    endcase
  end

  // Registered rate and status outputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      freq <= '0;
      status <= '0;
    end else begin
      freq.mult_khz <= next_mult_khz;
      // Clock held during changeover shows as zero rate
      freq.sys_khz <= sys_clk_hold ? 24'h000000 : next_sys_khz;
      freq.usb_khz <= usb_clk_hold ? 24'h000000 : next_usb_khz;
      status.mult_on <= mult_en;
      status.mult_locked <= mult_locked;
      status.crystal_valid <= src_sync.xtal_mode & src_sync.ext_settled;
      status.ext_periph_avail <= ext_ok;
    end
  end

  // Multiplier input choice driven to the analog block
  assign mult_input_sel = mult_sel;

  // Read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= `CCS_RDATA_IDLE;
    end else if (bus.rd && bus.addr == `CCS_ADDR_MULT) begin
      rdata <= {mult_en, mult_init, mult_locked, 3'b000, mult_sel};
    end else if (bus.rd && bus.addr == `CCS_ADDR_CLKSRC) begin
      rdata <= {1'b0, usb_field, 1'b0, sys_field};
    end else begin
      rdata <= `CCS_RDATA_IDLE;
    end
  end
endmodule : ccs_top

//--- test/ccs_top_chk.sv
// Port assertions for the clock control block
`include "ccs_regs.svh"

module ccs_chk
  import ccs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ccs_pkg::ccs_bus_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic [2:0] sys_sel,
  input wire logic [2:0] usb_sel,
  input wire logic sys_clk_hold,
  input wire logic usb_clk_hold,
  input wire ccs_pkg::ccs_status_t status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Gate window of a system clock changeover
  sequence sys_gate_s;
    sys_clk_hold [*8] ##1 !sys_clk_hold;
  endsequence
  // Gate window of a USB clock changeover
  sequence usb_gate_s;
    usb_clk_hold [*8] ##1 !usb_clk_hold;
  endsequence
  chk_rdata_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  chk_mult_enable_seen: assert property (bus.wr && bus.addr == `CCS_ADDR_MULT |->
    ##2 status.mult_on == $past(bus.wdata[7], 2)) else $error("enable not followed");
  chk_mult_pad_zero: assert property (bus.rd && bus.addr == `CCS_ADDR_MULT |->
    ##1 rdata[4:2] == 3'b000) else $error("multiplier pad bits set");
  chk_sel_pad_zero: assert property (bus.rd && bus.addr == `CCS_ADDR_CLKSRC |->
    ##1 (rdata[7] == 1'b0 && rdata[3] == 1'b0)) else $error("select pad bits set");
  chk_sys_gate_len: assert property ($rose(sys_clk_hold) |-> sys_gate_s)
    else $error("system gate window wrong");
  chk_usb_gate_len: assert property ($rose(usb_clk_hold) |-> usb_gate_s)
    else $error("usb gate window wrong");
  chk_sys_change_gated: assert property ($changed(sys_sel) |-> sys_clk_hold)
    else $error("system select changed ungated");
  chk_usb_change_gated: assert property ($changed(usb_sel) |-> usb_clk_hold)
    else $error("usb select changed ungated");
  chk_codes_legal: assert property (sys_sel <= 3'b100 && usb_sel <= 3'b101)
    else $error("reserved code applied");
endmodule : ccs_chk

bind ccs_top ccs_chk u_chk (.clk_sys, .sys_rst, .bus, .rdata, .sys_sel, .usb_sel,
  .sys_clk_hold, .usb_clk_hold, .status);

//--- test/tb_ccs_top.sv
// Self-checking bench for the clock control block
`include "ccs_regs.svh"

module tb_ccs_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccs_pkg::*;
  // Switch table: system code, usb code and expected rates in kHz
  localparam logic [2:0] SYS_TAB [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
  localparam logic [2:0] USB_TAB [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
  localparam int SYS_KHZ [6] = '{12000, 24000, 48000, 80, 12000, 12000};
  localparam int USB_KHZ [6] = '{6000, 12000, 6000, 4000, 3000, 48000};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  ccs_bus_req_t bus = '0;
  ccs_src_t src_pins = '0;
  logic int_osc_on = 1'b1;
  logic variant_48_strap = 1'b1;
  logic [7:0] rdata;
  logic [1:0] mult_input_sel;
  logic [2:0] sys_sel;
  logic [2:0] usb_sel;
  logic sys_clk_hold;
  logic usb_clk_hold;
  ccs_status_t status;
  ccs_freq_t freq;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] rd_val;

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  ccs_top uut (.clk_sys, .sys_rst, .bus, .rdata, .src_pins, .int_osc_on, .variant_48_strap,
    .mult_input_sel, .sys_sel, .usb_sel, .sys_clk_hold, .usb_clk_hold, .status, .freq);

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // One write cycle, then one quiet cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // One read cycle; data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys);
  endtask : rd

  task automatic t_reset_vals;
    rd(`CCS_ADDR_MULT, rd_val);
    check("mult_ctl reset", 24'(rd_val), 24'h00);
    rd(`CCS_ADDR_CLKSRC, rd_val);
    check("clk_sel reset", 24'(rd_val), 24'h00);
    check("usb_sel reset", 24'(usb_sel), 24'h0);
  endtask : t_reset_vals

  // All ones to both registers (pads, read-only flag, reserved codes), 0x55 to an unmapped place
  task automatic t_reg_bits;
    wr(`CCS_ADDR_MULT, 8'hff);
    wr(`CCS_ADDR_CLKSRC, 8'hff);
    wr(8'h10, 8'h55);
    rd(`CCS_ADDR_MULT, rd_val);
    check("mult_ctl pad", 24'(rd_val), 24'hc3);
    check("mult input", 24'(mult_input_sel), 24'h3);
    rd(`CCS_ADDR_CLKSRC, rd_val);
    check("clk_sel pad", 24'(rd_val), 24'h77);
    rd(8'h10, rd_val);
    check("unmapped", 24'(rd_val), 24'h00);
    idle(12);
    check("sys reserved", 24'(sys_sel), 24'h0);
    check("usb reserved", 24'(usb_sel), 24'h0);
    check("mult on", 24'(status.mult_on), 24'h1);
    check("no lock", 24'(status.mult_locked), 24'h0);
    wr(`CCS_ADDR_MULT, 8'h00);
    wr(`CCS_ADDR_CLKSRC, 8'h00);
  endtask : t_reg_bits

  // Crystal flag and a switch that waits for a settled source
  task automatic t_crystal;
    src_pins <= '{ext_settled: 1'b0, xtal_mode: 1'b1, lf_ready: 1'b1};
    idle(4);
    check("xtal unsettled", 24'(status.crystal_valid), 24'h0);
    wr(`CCS_ADDR_CLKSRC, 8'h01);
    idle(12);
    check("sys waits", 24'(sys_sel), 24'h0);
    src_pins.ext_settled <= 1'b1;
    idle(20);
    check("xtal valid", 24'(status.crystal_valid), 24'h1);
    check("sys ext", 24'(sys_sel), 24'h1);
    src_pins.xtal_mode <= 1'b0;
    wr(`CCS_ADDR_CLKSRC, 8'h00);
    idle(12);
    check("xtal mode off", 24'(status.crystal_valid), 24'h0);
    check("ext for periph", 24'(status.ext_periph_avail), 24'h1);
  endtask : t_crystal

  // Lock each multiplier input, ending on the internal oscillator
  task automatic t_mult_lock;
    logic [1:0] s;
    int n;
    for (int i = 2; i >= 0; i--) begin
      s = 2'(i);
      wr(`CCS_ADDR_MULT, 8'h00);
      rd(`CCS_ADDR_MULT, rd_val);
      check("lock cleared", 24'(rd_val[5]), 24'h0);
      wr(`CCS_ADDR_MULT, {6'h00, s});
      wr(`CCS_ADDR_MULT, {6'h20, s});
      idle(2);
      // external source settled since the crystal test
      wr(`CCS_ADDR_MULT, {6'h30, s});
      idle(395);
      rd(`CCS_ADDR_MULT, rd_val);
      check("lock early", 24'(rd_val[5]), 24'h0);
      n = 0;
      do begin
        rd(`CCS_ADDR_MULT, rd_val);
        n++;
      end while (rd_val[5] !== 1'b1 && n < 10);
      check("lock seen", 24'(rd_val[5]), 24'h1);
      // Poll bound used up: already counted, go to the verdict
      if (rd_val[5] !== 1'b1) begin
        report_and_stop();
      end
      idle(2);
      check("mult rate", freq.mult_khz, (i == 2) ? 24'd24000 : 24'd48000);
    end
  endtask : t_mult_lock

  // Live switching through every legal system and usb code
  task automatic t_switch;
    // USB picks include 48 and 6 MHz
    // system rates stay at or below 48 MHz
    for (int i = 0; i < 6; i++) begin
      wr(`CCS_ADDR_CLKSRC, {1'b0, USB_TAB[i], 1'b0, SYS_TAB[i]});
      idle(12);
      check("sys_sel", 24'(sys_sel), 24'(SYS_TAB[i]));
      check("usb_sel", 24'(usb_sel), 24'(USB_TAB[i]));
      check("sys rate", freq.sys_khz, 24'(SYS_KHZ[i]));
      check("usb rate", freq.usb_khz, 24'(USB_KHZ[i]));
    end
  endtask : t_switch

  // Mid-run reset with the strap low: full rate refused, internal enable honoured
  task automatic t_variant;
    variant_48_strap <= 1'b0;
    sys_rst <= 1'b1;
    idle(2);
    check("reset lock", 24'(status.mult_locked), 24'h0);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    wr(`CCS_ADDR_MULT, 8'h00);
    wr(`CCS_ADDR_MULT, 8'h80);
    idle(2);
    wr(`CCS_ADDR_MULT, 8'hc0);
    idle(402);
    check("relock", 24'(status.mult_locked), 24'h1);
    wr(`CCS_ADDR_CLKSRC, 8'h03);
    idle(12);
    check("full rate refused", 24'(sys_sel), 24'(`CCS_SYS_INT));
    wr(`CCS_ADDR_CLKSRC, 8'h02);
    idle(12);
    check("half rate", 24'(sys_sel), 24'(`CCS_SYS_MULT2));
    int_osc_on <= 1'b0;
    wr(`CCS_ADDR_CLKSRC, 8'h00);
    idle(12);
    check("int off refused", 24'(sys_sel), 24'(`CCS_SYS_MULT2));
    int_osc_on <= 1'b1;
    idle(12);
    check("int at once", 24'(sys_sel), 24'(`CCS_SYS_INT));
  endtask : t_variant

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset_vals();
    t_reg_bits();
    t_crystal();
    t_mult_lock();
    t_switch();
    t_variant();
    report_and_stop();
  end
endmodule : tb_ccs_top
